// file: spc_pkg.sv
// constants, register map and state type of the sampling pll clock control block
package spc_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int FIELD_W = 4;
   localparam int MODE_W = 2;

   // register offsets
   localparam logic [11:0] ADDR_NOISE_CTRL = 12'h02B;
   localparam logic [11:0] ADDR_PLL_DIV = 12'h03D;
   localparam logic [11:0] ADDR_FB_DIV = 12'h03E;
   localparam logic [11:0] ADDR_PLL_RESET = 12'h05C;
   localparam logic [11:0] ADDR_CAL_EN = 12'h05D;
   localparam logic [11:0] ADDR_CAL_DONE = 12'h05E;
   localparam logic [11:0] ADDR_LOCK = 12'h208;
   localparam logic [11:0] ADDR_BREF_EN = 12'h060;
   localparam logic [11:0] ADDR_TRIG_CTRL = 12'h061;
   localparam logic [11:0] ADDR_CMOS_CTRL = 12'h062;

   // field positions
   localparam int NOISE_ANA_BIT = 0;
   localparam int NOISE_CLK_BIT = 1;
   localparam int PRESCALE_LSB = 0;
   localparam int VCODIV_LSB = 4;
   localparam int TRIG_EN_BIT = 0;
   localparam int TRIG_MODE_LSB = 1;
   localparam int TRIG_DIV_LSB = 4;
   localparam int CMOS_OVR_BIT = 0;
   localparam int CMOS_C_LSB = 1;
   localparam int CMOS_D_LSB = 3;
   localparam int CMOS_OVREN_BIT = 5;

   // reset values
   localparam logic [7:0] RST_NOISE = 8'h00;
   localparam logic [7:0] RST_PLL_DIV = 8'h00;
   localparam logic [7:0] RST_FB_DIV = 8'h00;
   localparam logic [7:0] RST_PLL_RESET = 8'h01;
   localparam logic [7:0] RST_CAL_EN = 8'h00;
   localparam logic [7:0] RST_BREF_EN = 8'h01;
   localparam logic [7:0] RST_TRIG = 8'h00;
   localparam logic [7:0] RST_CMOS = 8'h00;

   // encodings
   localparam logic [1:0] TRIG_MODE_TSTAMP = 2'h3;
   localparam logic [1:0] REF_OFF = 2'h0;
   localparam logic [1:0] REF_FULL = 2'h1;
   localparam logic [1:0] REF_DIV2 = 2'h2;
   localparam logic [1:0] REF_DIV4 = 2'h3;
   localparam int NUM_PRODUCTS = 6;
   localparam logic [7:0] VALID_PRODUCTS [NUM_PRODUCTS] =
      '{8'h05, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h10};

   // timing
   localparam int CLK_MHZ = 100;
   localparam int CAL_TIME_NS = 1000;
   localparam int LOCK_TIME_NS = 500;
   localparam int CAL_CYCLES = (CAL_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int LOCK_CYCLES = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [3:0] {
      ST_HOLD = 4'h1,
      ST_CAL = 4'h2,
      ST_LOCKING = 4'h4,
      ST_LOCKED = 4'h8
   } spc_pll_state_t;
endpackage : spc_pkg

// file: spc_clock_ctrl.sv
// sampling pll sequencing, divider registers and clock output selection
//
// What this block does
// - lock is only reached for prescaler times vco divider of 5,6,8,10,12,16.
// - prescaler and vco divider sit at 0x3D, feedback divider at 0x3E.
// - clearing the pll reset control starts the vco calibration if bit 0 of the calibration enable at 0x5D is set.
// - calibration done reads 1 at 0x5E and lock reads 1 at 0x208.
// - two supply noise suppression enables are bits of register 0x2B.
// - buffered reference repeats the reference input chosen by the select pin.
// - buffered reference is on with the pll enabled unless its enable is 0.
// - buffered reference needs pll enable high and power down low.
// - trigger output comes from the timestamp input or the serializer clock.
// - trigger output is off after reset until software enables it.
// - serializer clock is divided by the receiver divider for the trigger output.
// - both cmos clock outputs follow the config pins and stop under power down.
// - register mode fields replace the config pins when override is set.
// - pins set enable and divider of channel c, only enable of channel d.
// - a cmos clock function wins over the over-range indication.
// - channel d clock works only while channel c clock mode is nonzero.
// - mode 0 off or over-range, 1 reference, 2 half, 3 quarter.
`timescale 1ns/1ps
`default_nettype none
module spc_clock_ctrl (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   input wire logic [spc_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [spc_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [spc_pkg::DATA_W-1:0] reg_rdata_out,
   output logic reg_rdata_valid_out,
   input wire logic pll_enable_pin_in,
   input wire logic power_down_pin_in,
   input wire logic single_ended_ref_select_in,
   input wire logic diff_clock_input_in,
   input wire logic single_ended_clock_input_in,
   input wire logic timestamp_input_in,
   input wire logic serdes_pll_clock_in,
   input wire logic [1:0] clock_config_pins_in,
   input wire logic overrange_c_in,
   input wire logic overrange_d_in,
   output logic buffered_reference_out,
   output logic trigger_clock_output,
   output logic channel_c_cmos_clock_out,
   output logic channel_d_cmos_clock_out,
   output logic [spc_pkg::FIELD_W-1:0] pll_prescaler_out,
   output logic [spc_pkg::FIELD_W-1:0] pll_vco_divider_out,
   output logic [spc_pkg::DATA_W-1:0] pll_feedback_divider_out,
   output logic pll_in_reset_out,
   output logic vco_cal_running_out,
   output logic analog_supply_rail_suppress_out,
   output logic clock_supply_rail_suppress_out
);
   import spc_pkg::*;

   logic [7:0] clock_noise_suppress_ctrl;
   logic [7:0] pll_divider_reg;
   logic [7:0] pll_feedback_divider;
   logic [7:0] sampling_pll_reset;
   logic [7:0] vco_calibration_enable;
   logic [7:0] buffered_reference_out_enable;
   logic [7:0] trigger_output_control;
   logic [7:0] cmos_clock_ctrl;
   spc_pll_state_t state, next_state;
   logic [7:0] cnt, next_cnt;
   logic ref_q, serdes_q;
   logic [1:0] ref_div_cnt;
   logic [3:0] rx_cnt, next_rx_cnt;

   // register decode
   wire wr_noise = reg_write_in && reg_addr_in == ADDR_NOISE_CTRL;
   wire wr_div = reg_write_in && reg_addr_in == ADDR_PLL_DIV;
   wire wr_fb = reg_write_in && reg_addr_in == ADDR_FB_DIV;
   wire wr_rst = reg_write_in && reg_addr_in == ADDR_PLL_RESET;
   wire wr_cal = reg_write_in && reg_addr_in == ADDR_CAL_EN;
   wire wr_bref = reg_write_in && reg_addr_in == ADDR_BREF_EN;
   wire wr_trig = reg_write_in && reg_addr_in == ADDR_TRIG_CTRL;
   wire wr_cmos = reg_write_in && reg_addr_in == ADDR_CMOS_CTRL;

   wire [3:0] prescale = pll_divider_reg[PRESCALE_LSB +: FIELD_W];
   wire [3:0] vco_div = pll_divider_reg[VCODIV_LSB +: FIELD_W];
   wire [7:0] product = prescale * vco_div;
   logic product_ok;
   always_comb begin
      product_ok = 1'b0;
      for (int i = 0; i < NUM_PRODUCTS; i++) begin
         if (product == VALID_PRODUCTS[i]) begin
            product_ok = 1'b1;
         end
      end
   end

   wire cal_done = (state == ST_LOCKING) || (state == ST_LOCKED);
   wire locked = state == ST_LOCKED;
   // reset register, pll disable pin or power down all hold the loop
   wire hold = sampling_pll_reset[0] || !pll_enable_pin_in || power_down_pin_in;

   wire [7:0] rd_mux =
      (reg_addr_in == ADDR_NOISE_CTRL) ? clock_noise_suppress_ctrl :
      (reg_addr_in == ADDR_PLL_DIV) ? pll_divider_reg :
      (reg_addr_in == ADDR_FB_DIV) ? pll_feedback_divider :
      (reg_addr_in == ADDR_PLL_RESET) ? sampling_pll_reset :
      (reg_addr_in == ADDR_CAL_EN) ? vco_calibration_enable :
      (reg_addr_in == ADDR_CAL_DONE) ? {7'h00, cal_done} :
      (reg_addr_in == ADDR_LOCK) ? {7'h00, locked} :
      (reg_addr_in == ADDR_BREF_EN) ? buffered_reference_out_enable :
      (reg_addr_in == ADDR_TRIG_CTRL) ? trigger_output_control :
      (reg_addr_in == ADDR_CMOS_CTRL) ? cmos_clock_ctrl : 8'h00;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         clock_noise_suppress_ctrl <= RST_NOISE;
         pll_divider_reg <= RST_PLL_DIV;
         pll_feedback_divider <= RST_FB_DIV;
         sampling_pll_reset <= RST_PLL_RESET;
         vco_calibration_enable <= RST_CAL_EN;
         buffered_reference_out_enable <= RST_BREF_EN;
         trigger_output_control <= RST_TRIG;
         cmos_clock_ctrl <= RST_CMOS;
      end else if (clk_en_in) begin
         if (wr_noise) clock_noise_suppress_ctrl <= reg_wdata_in;
         if (wr_div) pll_divider_reg <= reg_wdata_in;
         if (wr_fb) pll_feedback_divider <= reg_wdata_in;
         if (wr_rst) sampling_pll_reset <= reg_wdata_in;
         if (wr_cal) vco_calibration_enable <= reg_wdata_in;
         if (wr_bref) buffered_reference_out_enable <= reg_wdata_in;
         if (wr_trig) trigger_output_control <= reg_wdata_in;
         if (wr_cmos) cmos_clock_ctrl <= reg_wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= 8'h00;
         reg_rdata_valid_out <= 1'b0;
      end else if (clk_en_in) begin
         reg_rdata_valid_out <= reg_read_in;
         if (reg_read_in) reg_rdata_out <= rd_mux;
      end
   end

   // calibration and lock sequencing
   always_comb begin
      next_state = state;
      next_cnt = cnt + 8'h01;
      case (state)
         ST_HOLD: begin
            next_cnt = 8'h00;
            // without calibration the vco is untuned, so the loop stays put
            if (!hold && vco_calibration_enable[0]) next_state = ST_CAL;
         end
         ST_CAL: begin
            if (cnt == 8'(CAL_CYCLES - 1)) begin
               next_state = ST_LOCKING;
               next_cnt = 8'h00;
            end
         end
         ST_LOCKING: begin
            // unsupported divisor products never lock
            if (!product_ok || pll_feedback_divider == 8'h00) begin
               next_cnt = 8'h00;
            end else if (cnt == 8'(LOCK_CYCLES - 1)) begin
               next_state = ST_LOCKED;
               next_cnt = 8'h00;
            end
         end
         ST_LOCKED: next_cnt = 8'h00;
         default: next_state = ST_HOLD;
      endcase
      if (hold) begin
         next_state = ST_HOLD;
         next_cnt = 8'h00;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= ST_HOLD;
         cnt <= 8'h00;
      end else if (clk_en_in) begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // reference selection and dividers
   wire sel_ref = single_ended_ref_select_in ? single_ended_clock_input_in
                                             : diff_clock_input_in;
   wire ref_rise = sel_ref && !ref_q;
   wire ovr_sel = cmos_clock_ctrl[CMOS_OVR_BIT];
   wire overrange_output_enable = cmos_clock_ctrl[CMOS_OVREN_BIT];
   wire [1:0] c_mode = ovr_sel ? cmos_clock_ctrl[CMOS_C_LSB +: MODE_W]
                               : clock_config_pins_in;
   // pins only switch channel d on or off, at the undivided reference
   wire [1:0] d_pin_mode = (clock_config_pins_in != 2'h0) ? REF_FULL : REF_OFF;
   wire [1:0] d_mode = ovr_sel ? cmos_clock_ctrl[CMOS_D_LSB +: MODE_W] : d_pin_mode;
   wire c_is_clock = c_mode != REF_OFF;
   wire d_is_clock = (d_mode != REF_OFF) && c_is_clock;

   function automatic logic mode_level(input logic [1:0] mode, input logic full,
                                       input logic [1:0] dcnt);
      logic lvl;
      lvl = 1'b0;
      case (mode)
         REF_FULL: lvl = full;
         REF_DIV2: lvl = dcnt[0];
         REF_DIV4: lvl = dcnt[1];
         default: lvl = 1'b0;
      endcase
      return lvl;
   endfunction : mode_level

   wire c_clock_level = mode_level(c_mode, sel_ref, ref_div_cnt);
   wire d_clock_level = mode_level(d_mode, sel_ref, ref_div_cnt);
   wire next_c_out = !power_down_pin_in &&
      (c_is_clock ? c_clock_level : (overrange_output_enable && overrange_c_in));
   wire next_d_out = !power_down_pin_in &&
      (d_is_clock ? d_clock_level : (overrange_output_enable && overrange_d_in));
   wire next_bref = pll_enable_pin_in && !power_down_pin_in &&
      buffered_reference_out_enable[0] && sel_ref;

   // serializer clock divider for the trigger output
   wire [3:0] rx_div = trigger_output_control[TRIG_DIV_LSB +: FIELD_W];
   wire [3:0] rx_last = (rx_div == 4'h0) ? 4'h0 : rx_div - 4'h1;
   wire serdes_rise = serdes_pll_clock_in && !serdes_q;
   always_comb begin
      next_rx_cnt = rx_cnt;
      if (serdes_rise) next_rx_cnt = (rx_cnt >= rx_last) ? 4'h0 : rx_cnt + 4'h1;
   end
   // divide by one passes the clock through; odd divisors give an uneven duty
   wire serdes_div_level = (rx_div <= 4'h1) ? serdes_pll_clock_in
                                            : (rx_cnt < {1'b0, rx_div[3:1]});
   wire trig_tstamp = trigger_output_control[TRIG_MODE_LSB +: MODE_W] == TRIG_MODE_TSTAMP;
   wire next_trig = trigger_output_control[TRIG_EN_BIT] &&
      (trig_tstamp ? timestamp_input_in : serdes_div_level);

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ref_q <= 1'b0;
         serdes_q <= 1'b0;
         ref_div_cnt <= 2'h0;
         rx_cnt <= 4'h0;
         buffered_reference_out <= 1'b0;
         trigger_clock_output <= 1'b0;
         channel_c_cmos_clock_out <= 1'b0;
         channel_d_cmos_clock_out <= 1'b0;
      end else if (clk_en_in) begin
         ref_q <= sel_ref;
         serdes_q <= serdes_pll_clock_in;
         if (ref_rise) ref_div_cnt <= ref_div_cnt + 2'h1;
         rx_cnt <= next_rx_cnt;
         buffered_reference_out <= next_bref;
         trigger_clock_output <= next_trig;
         channel_c_cmos_clock_out <= next_c_out;
         channel_d_cmos_clock_out <= next_d_out;
      end
   end

   assign pll_prescaler_out = prescale;
   assign pll_vco_divider_out = vco_div;
   assign pll_feedback_divider_out = pll_feedback_divider;
   assign pll_in_reset_out = state == ST_HOLD;
   assign vco_cal_running_out = state == ST_CAL;
   assign analog_supply_rail_suppress_out = clock_noise_suppress_ctrl[NOISE_ANA_BIT];
   assign clock_supply_rail_suppress_out = clock_noise_suppress_ctrl[NOISE_CLK_BIT];

   a_lock_product: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      locked |-> product_ok && pll_feedback_divider != 8'h00)
      else $error("pll locked with unsupported divider setting");
   a_cal_start: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      clk_en_in && state == ST_HOLD && !hold && vco_calibration_enable[0]
      |=> state == ST_CAL)
      else $error("calibration did not start on reset release");
   a_reset_clears: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      clk_en_in && sampling_pll_reset[0] |=> !cal_done && !locked)
      else $error("status not cleared by pll reset");
   a_done_before_lock: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      $rose(locked) |-> $past(state) == ST_LOCKING && cal_done)
      else $error("lock without completed calibration");
   a_bref_gating: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      clk_en_in && (power_down_pin_in || !pll_enable_pin_in) |=> !buffered_reference_out)
      else $error("buffered reference active while disabled");
   a_trig_off: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      clk_en_in && !trigger_output_control[TRIG_EN_BIT] |=> !trigger_clock_output)
      else $error("trigger output active while disabled");
   a_cmos_pd: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      clk_en_in && power_down_pin_in |=> !channel_c_cmos_clock_out
      && !channel_d_cmos_clock_out)
      else $error("cmos clock output active under power down");
   a_d_needs_c: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      clk_en_in && !c_is_clock && !overrange_output_enable |=> !channel_d_cmos_clock_out)
      else $error("channel d clock without channel c clock");
   a_c_priority: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      clk_en_in && c_is_clock && !power_down_pin_in
      |=> channel_c_cmos_clock_out == $past(c_clock_level))
      else $error("over-range overrode channel c clock");
   c_locked: cover property (@(posedge ref_clk_in) disable iff (!resetn_in) $rose(locked));
   c_trig_tstamp: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
      trig_tstamp && trigger_clock_output);
   c_c_div4: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
      c_mode == REF_DIV4 && channel_c_cmos_clock_out);
endmodule : spc_clock_ctrl
`default_nettype wire

// file: spc_clock_sink.sv
// receiving end model that counts rising edges on the four clock outputs
`timescale 1ns/1ps
`default_nettype none
module spc_clock_sink (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [3:0] clocks_in,
   output logic [63:0] edge_counts_out
);
   logic [3:0] last;

   // sampled like a fabric register would, so only full-cycle levels count
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         last <= 4'h0;
         edge_counts_out <= '0;
      end else begin
         last <= clocks_in;
         for (int i = 0; i < 4; i++) begin
            if (clocks_in[i] && !last[i]) begin
               edge_counts_out[i*16 +: 16] <= edge_counts_out[i*16 +: 16] + 16'h0001;
            end
         end
      end
   end
endmodule : spc_clock_sink
`default_nettype wire

// file: test_sampling_pll_clock_outputs.sv
// self-checking bench for the sampling pll clock control block
`timescale 1ns/1ps
`default_nettype none
module test_sampling_pll_clock_outputs;
   import spc_pkg::*;
   localparam logic [7:0] DIVS [7] = '{8'h15, 8'h16, 8'h24, 8'h25, 8'h34, 8'h44, 8'h17};
   localparam logic [7:0] TRIG_SET [5] = '{8'h07, 8'h41, 8'h21, 8'h01, 8'h40};
   localparam logic [7:0] TRIG_EXP [5] = '{8'h04, 8'h06, 8'h0C, 8'h18, 8'h00};
   // pins, control, channel c edges, channel d edges
   localparam logic [31:0] CMOS_SET [11] = '{32'h01000C0C, 32'h0200060C, 32'h0300030C,
      32'h00200000, 32'h01200C0C, 32'h00170306, 32'h001D0603, 32'h000B0C0C,
      32'h00290000, 32'h00090000, 32'h00000000};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic ce = 1'b1;
   logic pll_pin = 1'b1;
   logic pd = 1'b0;
   logic sel = 1'b0;
   logic diff_ck = 1'b0;
   logic se_ck = 1'b0;
   logic ts = 1'b0;
   logic sd_ck = 1'b0;
   logic [1:0] cfg = 2'h0;
   logic ovr_c = 1'b0;
   logic ovr_d = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] fbdiv;
   logic [FIELD_W-1:0] presc, vdiv;
   logic rvalid, bref, trig, cmos_c, cmos_d, in_rst, cal_run, sup_a, sup_c;
   logic [63:0] edges;
   int gen_cnt = 0;
   int bad_count = 0;
   int num_checks = 0;

   always #5 clk = ~clk;
   // stimulus clocks of period 4, 6, 12 and 2 cycles; 48-cycle windows hold whole periods
   always @(posedge clk) begin
      gen_cnt <= gen_cnt + 1;
      diff_ck <= gen_cnt[1];
      se_ck <= (gen_cnt % 6) < 3;
      ts <= (gen_cnt % 12) < 6;
      sd_ck <= gen_cnt[0];
   end

   spc_clock_ctrl i_dut (.ref_clk_in(clk), .resetn_in(rstn), .clk_en_in(ce),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
      .reg_rdata_out(rdata), .reg_rdata_valid_out(rvalid), .pll_enable_pin_in(pll_pin),
      .power_down_pin_in(pd), .single_ended_ref_select_in(sel),
      .diff_clock_input_in(diff_ck), .single_ended_clock_input_in(se_ck),
      .timestamp_input_in(ts), .serdes_pll_clock_in(sd_ck), .clock_config_pins_in(cfg),
      .overrange_c_in(ovr_c), .overrange_d_in(ovr_d), .buffered_reference_out(bref),
      .trigger_clock_output(trig), .channel_c_cmos_clock_out(cmos_c),
      .channel_d_cmos_clock_out(cmos_d), .pll_prescaler_out(presc),
      .pll_vco_divider_out(vdiv), .pll_feedback_divider_out(fbdiv),
      .pll_in_reset_out(in_rst), .vco_cal_running_out(cal_run),
      .analog_supply_rail_suppress_out(sup_a), .clock_supply_rail_suppress_out(sup_c));

   spc_clock_sink i_sink (.clk_in(clk), .resetn_in(rstn),
      .clocks_in({cmos_d, cmos_c, trig, bref}), .edge_counts_out(edges));

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report

   task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : reg_wr

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("read valid", {7'h0, rvalid}, 8'h01);
      check($sformatf("reg %0h", a), rdata, exp);
   endtask : rd_chk

   // counts over a whole number of periods, so the phase of the window does not matter
   task automatic edge_chk(input int idx, input logic [7:0] exp, input string name);
      logic [15:0] c0;
      repeat (24) @(posedge clk);
      #1;
      c0 = edges[idx*16 +: 16];
      repeat (48) @(posedge clk);
      #1;
      check(name, 8'(edges[idx*16 +: 16] - c0), exp);
   endtask : edge_chk

   task automatic t_reset();
      check("held", {7'h0, in_rst}, 8'h01);
      check("trigger idle", {7'h0, trig}, 8'h00);
      rd_chk(ADDR_PLL_RESET, RST_PLL_RESET);
      rd_chk(ADDR_BREF_EN, RST_BREF_EN);
      rd_chk(ADDR_TRIG_CTRL, RST_TRIG);
      reg_wr(ADDR_CAL_DONE, 8'hFF);
      reg_wr(ADDR_LOCK, 8'hFF);
      reg_wr(12'h100, 8'hFF);
      rd_chk(ADDR_CAL_DONE, 8'h00);
      rd_chk(ADDR_LOCK, 8'h00);
      rd_chk(12'h100, 8'h00);
      edge_chk(1, 8'h00, "trigger off");
      $display("test reset done");
   endtask : t_reset

   task automatic t_pll();
      for (int i = 0; i < 7; i++) begin
         reg_wr(ADDR_PLL_RESET, 8'h01);
         reg_wr(ADDR_PLL_DIV, DIVS[i]);
         reg_wr(ADDR_FB_DIV, 8'h08);
         reg_wr(ADDR_CAL_EN, 8'h01);
         check("dividers", {vdiv, presc}, DIVS[i]);
         check("feedback", fbdiv, 8'h08);
         reg_wr(ADDR_PLL_RESET, 8'h00);
         repeat (3) @(posedge clk);
         #1;
         check("calibrating", {6'h0, in_rst, cal_run}, 8'h01);
         rd_chk(ADDR_CAL_DONE, 8'h00);
         repeat (200) @(posedge clk);
         rd_chk(ADDR_CAL_DONE, 8'h01);
         rd_chk(ADDR_LOCK, {7'h0, i < 6});
      end
      // pll enable pin low bypasses the loop: the sequence must fall back to hold
      @(posedge clk) pll_pin <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("pll bypassed", {7'h0, in_rst}, 8'h01);
      @(posedge clk) pll_pin <= 1'b1;
      reg_wr(ADDR_PLL_RESET, 8'h01);
      reg_wr(ADDR_CAL_EN, 8'h00);
      reg_wr(ADDR_PLL_RESET, 8'h00);
      repeat (200) @(posedge clk);
      check("no cal enable", {7'h0, in_rst}, 8'h01);
      rd_chk(ADDR_LOCK, 8'h00);
      $display("test pll sequence done");
   endtask : t_pll

   task automatic t_noise();
      reg_wr(ADDR_NOISE_CTRL, 8'h01);
      check("suppress", {6'h0, sup_c, sup_a}, 8'h01);
      reg_wr(ADDR_NOISE_CTRL, 8'h02);
      check("suppress", {6'h0, sup_c, sup_a}, 8'h02);
      rd_chk(ADDR_NOISE_CTRL, 8'h02);
      // clock enable low must freeze registers and clock outputs alike
      @(posedge clk) ce <= 1'b0;
      reg_wr(ADDR_NOISE_CTRL, 8'h01);
      check("frozen suppress", {6'h0, sup_c, sup_a}, 8'h02);
      edge_chk(0, 8'h00, "frozen bref");
      @(posedge clk) ce <= 1'b1;
      $display("test noise done");
   endtask : t_noise

   task automatic t_bref();
      edge_chk(0, 8'h0C, "bref diff");
      @(posedge clk) sel <= 1'b1;
      edge_chk(0, 8'h08, "bref single");
      reg_wr(ADDR_BREF_EN, 8'h00);
      edge_chk(0, 8'h00, "bref disabled");
      reg_wr(ADDR_BREF_EN, 8'h01);
      @(posedge clk) pd <= 1'b1;
      edge_chk(0, 8'h00, "bref power down");
      @(posedge clk) pd <= 1'b0;
      @(posedge clk) pll_pin <= 1'b0;
      edge_chk(0, 8'h00, "bref pll off");
      @(posedge clk) pll_pin <= 1'b1;
      @(posedge clk) sel <= 1'b0;
      edge_chk(0, 8'h0C, "bref back");
      $display("test buffered reference done");
   endtask : t_bref

   task automatic t_trig();
      for (int i = 0; i < 5; i++) begin
         reg_wr(ADDR_TRIG_CTRL, TRIG_SET[i]);
         edge_chk(1, TRIG_EXP[i], "trigger edges");
      end
      $display("test trigger done");
   endtask : t_trig

   task automatic t_cmos();
      logic [31:0] e;
      for (int i = 0; i < 11; i++) begin
         e = CMOS_SET[i];
         @(posedge clk);
         cfg <= e[25:24];
         ovr_c <= 1'b1;
         ovr_d <= 1'b1;
         reg_wr(ADDR_CMOS_CTRL, e[23:16]);
         edge_chk(2, e[15:8], "cmos c edges");
         edge_chk(3, e[7:0], "cmos d edges");
         if (e[15:0] == 16'h0000) begin
            check("cmos levels", {6'h0, cmos_d, cmos_c}, {6'h0, {2{e[21]}}});
         end
      end
      @(posedge clk) cfg <= 2'h1;
      reg_wr(ADDR_CMOS_CTRL, 8'h20);
      @(posedge clk) pd <= 1'b1;
      edge_chk(2, 8'h00, "cmos c power down");
      edge_chk(3, 8'h00, "cmos d power down");
      check("cmos pd levels", {6'h0, cmos_d, cmos_c}, 8'h00);
      @(posedge clk) pd <= 1'b0;
      $display("test cmos outputs done");
   endtask : t_cmos

   // a second reset in mid-run must bring back the startup state
   task automatic t_rerun();
      @(posedge clk) rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      #1;
      check("re-reset held", {7'h0, in_rst}, 8'h01);
      check("re-reset trigger", {7'h0, trig}, 8'h00);
      rd_chk(ADDR_TRIG_CTRL, RST_TRIG);
      rd_chk(ADDR_CMOS_CTRL, RST_CMOS);
      $display("test second reset done");
   endtask : t_rerun

   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      #1;
      t_reset();
      t_pll();
      t_noise();
      t_bref();
      t_trig();
      t_cmos();
      t_rerun();
      final_report();
   end

   // a hang cuts the run short as a mismatch
   initial begin
      repeat (90000) @(posedge clk);
      bad_count++;
      final_report();
   end
endmodule : test_sampling_pll_clock_outputs
`default_nettype wire
